// ---- include/timer_pkg.sv ----
package timer_pkg;
    // Register byte offsets on the APB port.
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_COUNT = 8'h04;
    localparam logic [7:0] OFS_COMPARE = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h0C;
    localparam logic [7:0] OFS_FLAGS = 8'h10;
    // Control register field positions.
    localparam int FORCE_BIT = 7;
    localparam int WAVE_HI_BIT = 6;
    localparam int WAVE_LO_BIT = 3;
    localparam int OUT_MODE_HI = 5;
    localparam int OUT_MODE_LO = 4;
    localparam int CLK_SEL_HI = 2;
    // Mask and flag bit positions.
    localparam int CMP_BIT = 1;
    localparam int OVF_BIT = 0;
    // Reset value and counter end points.
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    // Prescaler divide ratios; DIV_1024 holds the last prescaler count, 1023.
    localparam logic [9:0] DIV_8 = 10'h008;
    localparam logic [9:0] DIV_64 = 10'h040;
    localparam logic [9:0] DIV_256 = 10'h100;
    localparam logic [9:0] DIV_1024 = 10'h3FF;
    // Waveform modes.
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_PHASE_PWM = 2'b01,
        MODE_CLEAR_MATCH = 2'b10,
        MODE_FAST_PWM = 2'b11
    } wave_mode_e;
    // Clock sources.
    typedef enum logic [2:0] {
        CLK_STOP = 3'b000,
        CLK_DIV1 = 3'b001,
        CLK_DIV8 = 3'b010,
        CLK_DIV64 = 3'b011,
        CLK_DIV256 = 3'b100,
        CLK_DIV1024 = 3'b101,
        CLK_EXT_FALL = 3'b110,
        CLK_EXT_RISE = 3'b111
    } clk_source_e;
endpackage

// ---- core/timer8.sv ----
`timescale 1ns/1ps
// Contract
// [RULE_01] Force bit applies match in non-PWM modes
// [RULE_02] Force sets no flag, never clears counter
// [RULE_03] Force bit always reads zero
// [RULE_04] Software writes force zero in PWM
// [RULE_05] Mode field selects four modes, top
// [RULE_06] Compare buffering and overflow point per mode
// [RULE_07] Output overrides port when mode nonzero
// [RULE_08] Non-PWM output: off, toggle, clear, set
// [RULE_09] Fast PWM: clear/set on match, reverse at top
// [RULE_10] Phase PWM: up and down match actions
// [RULE_11] PWM compare at top: act at top
// [RULE_12] Clock select: stop, prescales, external edges
// [RULE_13] External pin counts even as output
// [RULE_14] Counter write blocks next compare match
// [RULE_15] Compare each cycle feeds flag and output
// [RULE_16] Compare interrupt needs enable, global, flag
// [RULE_17] Overflow interrupt needs enable, global, flag
// [RULE_18] Compare flag: vector or write-one clears
// [RULE_19] Overflow flag: vector or write-one clears
// [RULE_20] Phase PWM overflow at bottom turn
// [RULE_21] Upper mask bits left reserved
// [RULE_22] Fast PWM wraps MAX to zero
// [RULE_23] Phase PWM holds MAX once, counts down
// [RULE_24] All logic advances on timer clock enable; prescaler, synchroniser, bus writes, force and flag clears act every pclk
module timer8
    import timer_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_count_pin,
    input wire logic global_irq_en,
    input wire logic cmp_vector_ack,
    input wire logic ovf_vector_ack,
    output logic cmp_irq_req,
    output logic ovf_irq_req,
    output logic compare_out_pin,
    output logic compare_out_override
);
    // Tick from the free prescaler when its low bits wrap.
    function automatic logic div_tick(input logic [9:0] cnt, input logic [9:0] div);
        div_tick = ((cnt & (div - 10'h001)) == (div - 10'h001));
    endfunction

    // Non-PWM output action for one compare event; shared by match and force.
    function automatic logic match_action(input logic [1:0] om, input logic cur);
        case (om)
            2'b01: match_action = !cur;
            2'b10: match_action = 1'b0;
            2'b11: match_action = 1'b1;
            default: match_action = cur;
        endcase
    endfunction

    logic [7:0] control_q;
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic [7:0] compare_buf_q;
    logic [7:0] compare_act_q;
    logic [1:0] mask_q;
    logic cmp_flag_q;
    logic ovf_flag_q;
    logic down_q;
    logic block_q;
    logic out_q;
    logic out_d;
    logic [9:0] presc_q;
    logic [2:0] ext_sync_q;
    logic [31:0] prdata_q;

    // Bus decode; the slave never waits, so pready is constant high.
    wire setup_ph = psel && !penable;
    wire wr_acc = psel && penable && pwrite;
    wire hit_ctl = (paddr == OFS_CONTROL);
    wire hit_cnt = (paddr == OFS_COUNT);
    wire hit_cmp = (paddr == OFS_COMPARE);
    wire hit_msk = (paddr == OFS_MASK);
    wire hit_flg = (paddr == OFS_FLAGS);
    wire mapped = hit_ctl || hit_cnt || hit_cmp || hit_msk || hit_flg;
    wire ctl_wr = wr_acc && hit_ctl;
    wire cnt_wr = wr_acc && hit_cnt;
    wire cmp_wr = wr_acc && hit_cmp;
    wire msk_wr = wr_acc && hit_msk;
    wire flg_wr = wr_acc && hit_flg;

    // Mode fields.
    wave_mode_e mode;
    clk_source_e clk_sel;
    // [RULE_05] mode field split
    assign mode = wave_mode_e'({control_q[WAVE_HI_BIT], control_q[WAVE_LO_BIT]});
    assign clk_sel = clk_source_e'(control_q[CLK_SEL_HI:0]);
    wire [1:0] out_mode = control_q[OUT_MODE_HI:OUT_MODE_LO];
    wire pwm = (mode == MODE_PHASE_PWM) || (mode == MODE_FAST_PWM);
    wire [7:0] top = (mode == MODE_CLEAR_MATCH) ? compare_act_q : COUNT_MAX;

    // External edges are seen on the synchronised copy, the pin drive ignored.
    wire ext_rise = ext_sync_q[1] && !ext_sync_q[2];
    wire ext_fall = !ext_sync_q[1] && ext_sync_q[2];

    // Timer clock enable selection.
    logic tick;
    // [RULE_12] clock select decode
    always_comb
    begin
        case (clk_sel)
            CLK_STOP: tick = 1'b0;
            CLK_DIV1: tick = 1'b1;
            CLK_DIV8: tick = div_tick(presc_q, DIV_8);
            CLK_DIV64: tick = div_tick(presc_q, DIV_64);
            CLK_DIV256: tick = div_tick(presc_q, DIV_256);
            CLK_DIV1024: tick = (presc_q == DIV_1024);
            // [RULE_13] pin edges count
            CLK_EXT_FALL: tick = ext_fall;
            CLK_EXT_RISE: tick = ext_rise;
            default: tick = 1'b0;
        endcase
    end

    // Compare is checked every cycle; a counter write hides one tick.
    // [RULE_15] continuous compare
    wire equal = (count_q == compare_act_q);
    // [RULE_14] write blocks match
    wire match = tick && equal && !block_q;
    wire at_max = (count_q == COUNT_MAX);
    wire at_top = tick && (count_q == top);
    // [RULE_06] overflow point per mode
    // [RULE_20] bottom turn overflow
    wire ovf_evt = tick && ((mode == MODE_PHASE_PWM) ?
        (down_q && count_q == COUNT_BOTTOM) : at_max);
    // [RULE_02] force only reaches the output
    wire force_evt = ctl_wr && pwdata[FORCE_BIT] && !pwdata[WAVE_LO_BIT];
    wire [1:0] force_mode = pwdata[OUT_MODE_HI:OUT_MODE_LO];
    wire cmp_is_top = (compare_act_q == COUNT_MAX) && out_mode[1];

    // Counter next value per mode.
    always_comb
    begin
        count_d = count_q;
        if (tick)
        begin
            case (mode)
                MODE_CLEAR_MATCH: count_d = (count_q == top) ? COUNT_BOTTOM : count_q + 8'h01;
                // [RULE_23] hold MAX then descend
                MODE_PHASE_PWM:
                begin
                    if (!down_q)
                        count_d = at_max ? count_q - 8'h01 : count_q + 8'h01;
                    else
                        count_d = (count_q == COUNT_BOTTOM) ? 8'h01 : count_q - 8'h01;
                end
                // [RULE_22] wrap at MAX
                default: count_d = count_q + 8'h01;
            endcase
        end
        if (cnt_wr)
            count_d = pwdata[7:0];
    end

    // Output waveform next value.
    always_comb
    begin
        out_d = out_q;
        case (mode)
            MODE_FAST_PWM:
            begin
                // [RULE_09] fast PWM actions
                if (out_mode[1] && match && !cmp_is_top)
                    out_d = out_mode[0];
                // [RULE_11] action at top
                if (out_mode[1] && tick && at_max)
                    out_d = !out_mode[0];
            end
            MODE_PHASE_PWM:
            begin
                // [RULE_10] up and down actions
                if (out_mode[1] && match && !cmp_is_top)
                    out_d = down_q ? !out_mode[0] : out_mode[0];
                // [RULE_11] action at top
                if (out_mode[1] && cmp_is_top && tick && at_max && !down_q)
                    out_d = !out_mode[0];
            end
            default:
            begin
                // [RULE_08] non-PWM actions
                if (match)
                    out_d = match_action(out_mode, out_q);
            end
        endcase
        // [RULE_01] forced match
        // The strobe acts with the output mode written alongside it, and it
        // overrides a real match in the same cycle so the action happens once.
        if (force_evt)
            out_d = match_action(force_mode, out_q);
    end

    // Read mux; the force bit is masked off.
    logic [7:0] rd_byte;
    always_comb
    begin
        rd_byte = RESET_BYTE;
        // [RULE_03] force reads zero
        if (hit_ctl)
            rd_byte = {1'b0, control_q[6:0]};
        if (hit_cnt)
            rd_byte = count_q;
        if (hit_cmp)
            rd_byte = compare_buf_q;
        // [RULE_21] upper mask bits zero
        if (hit_msk)
            rd_byte = {6'h00, mask_q};
        if (hit_flg)
            rd_byte = {6'h00, cmp_flag_q, ovf_flag_q};
    end

    // Prescaler and pin synchroniser run always.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            presc_q <= 10'h000;
            ext_sync_q <= 3'h0;
        end
        else
        begin
            presc_q <= (presc_q == DIV_1024) ? 10'h000 : presc_q + 10'h001;
            ext_sync_q <= {ext_sync_q[1:0], ext_count_pin};
        end
    end

    // Software registers.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            control_q <= RESET_BYTE;
            compare_buf_q <= RESET_BYTE;
            mask_q <= 2'h0;
        end
        else
        begin
            if (ctl_wr)
                control_q <= {1'b0, pwdata[6:0]};
            if (cmp_wr)
                compare_buf_q <= pwdata[7:0];
            if (msk_wr)
                mask_q <= pwdata[1:0];
        end
    end

    // [RULE_24] counter on timer tick
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_q <= RESET_BYTE;
            down_q <= 1'b0;
            block_q <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            if (mode != MODE_PHASE_PWM || cnt_wr)
                down_q <= 1'b0;
            else if (tick)
                down_q <= down_q ? (count_q != COUNT_BOTTOM) : at_max;
            block_q <= cnt_wr || (block_q && !tick);
        end
    end

    // [RULE_06] compare buffer load point
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            compare_act_q <= RESET_BYTE;
        else if (!pwm || at_top)
            compare_act_q <= cmp_wr ? pwdata[7:0] : compare_buf_q;
    end

    // Flags: a set in the same cycle as a clear wins.
    // [RULE_18] compare flag
    // [RULE_19] overflow flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmp_flag_q <= 1'b0;
            ovf_flag_q <= 1'b0;
            out_q <= 1'b0;
        end
        else
        begin
            cmp_flag_q <= match || (cmp_flag_q && !cmp_vector_ack
                && !(flg_wr && pwdata[CMP_BIT]));
            ovf_flag_q <= ovf_evt || (ovf_flag_q && !ovf_vector_ack
                && !(flg_wr && pwdata[OVF_BIT]));
            out_q <= out_d;
        end
    end

    // Read data is captured in the setup phase for a zero-wait access.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h0000_0000;
        else if (setup_ph)
            prdata_q <= {24'h000000, rd_byte};
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    // [RULE_16] compare request
    assign cmp_irq_req = mask_q[CMP_BIT] && global_irq_en && cmp_flag_q;
    // [RULE_17] overflow request
    assign ovf_irq_req = mask_q[OVF_BIT] && global_irq_en && ovf_flag_q;
    // [RULE_07] port override
    assign compare_out_override = (out_mode != 2'b00);
    assign compare_out_pin = out_q;

    // Checks on the counting, waveform, flag, interrupt and read-back logic.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    force_no_flag_a: assert property ($rose(cmp_flag_q) |-> $past(match)) // RULE_02
        else $error("compare flag set without a match");
    force_toggle_a: assert property ( // RULE_01
        (force_evt && force_mode == 2'b01)
        |=> (out_q != $past(out_q)))
        else $error("forced toggle did not change output");
    force_read_a: assert property ((setup_ph && hit_ctl) |=> !prdata[FORCE_BIT]) // RULE_03
        else $error("force bit read back as one");
    ctc_clear_a: assert property ( // RULE_05
        (tick && mode == MODE_CLEAR_MATCH && equal && !cnt_wr) |=> count_q == COUNT_BOTTOM)
        else $error("clear-on-match did not clear counter");
    write_block_a: assert property (cnt_wr |=> !match) // RULE_14
        else $error("match seen right after counter write");
    fast_wrap_a: assert property ( // RULE_22
        (tick && mode == MODE_FAST_PWM && at_max && !cnt_wr) |=> count_q == COUNT_BOTTOM)
        else $error("fast PWM did not wrap");
    phase_hold_a: assert property ( // RULE_23
        (tick && mode == MODE_PHASE_PWM && at_max && !down_q && !cnt_wr)
        |=> (count_q == 8'hFE) && down_q)
        else $error("phase PWM did not turn at MAX");
    bottom_ovf_a: assert property ( // RULE_20
        (tick && mode == MODE_PHASE_PWM && down_q && count_q == COUNT_BOTTOM)
        |=> ovf_flag_q)
        else $error("overflow flag missed at bottom turn");
    flag_clear_a: assert property ( // RULE_18
        (flg_wr && pwdata[CMP_BIT] && !match) |=> !cmp_flag_q)
        else $error("compare flag not cleared by write");
    cmp_irq_a: assert property ( // RULE_16
        (cmp_flag_q && mask_q[CMP_BIT] && global_irq_en) |-> cmp_irq_req)
        else $error("compare request missing");

    fast_pwm_c: cover property (mode == MODE_FAST_PWM && tick && at_max);
    phase_turn_c: cover property (mode == MODE_PHASE_PWM && ovf_evt);
    forced_c: cover property (force_evt ##1 out_q != $past(out_q));
    ext_clock_c: cover property (clk_sel == CLK_EXT_RISE && tick);
endmodule

// ---- verif/pin_model.sv ----
`timescale 1ns/1ps
// Board-side driver of the external count pin: bursts of clean pulses on request.
module pin_model
(
    input wire logic pclk,
    input wire logic [3:0] n_edges,
    input wire logic go,
    output logic ext_count_pin
);
    // Three cycles per level, so the two-flop synchroniser never misses an edge.
    initial
    begin
        ext_count_pin = 1'b0;
        forever
        begin
            @(posedge pclk);
            if (go)
            begin
                repeat (n_edges)
                begin
                    repeat (3) @(posedge pclk);
                    ext_count_pin <= 1'b1;
                    repeat (3) @(posedge pclk);
                    ext_count_pin <= 1'b0;
                end
                wait (!go);
            end
        end
    end
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/1ps
module tb
    import timer_pkg::*;
();
    logic pclk, presetn, psel, penable, pwrite, global_irq_en, cmp_vector_ack, ovf_vector_ack;
    logic pready, pslverr, cmp_irq_req, ovf_irq_req, compare_out_pin, compare_out_override;
    logic ext_count_pin, go;
    logic [3:0] n_edges;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [32:0] exp_q[$];
    string nm_q[$];
    int bad_count, n_tests, seed, n, hi, lo, r;
    int divs[5] = '{1, 8, 64, 256, 1024};
    logic [7:0] offs[5] = '{OFS_CONTROL, OFS_COUNT, OFS_COMPARE, OFS_MASK, OFS_FLAGS};

    timer8 dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_count_pin(ext_count_pin), .global_irq_en(global_irq_en),
        .cmp_vector_ack(cmp_vector_ack), .ovf_vector_ack(ovf_vector_ack),
        .cmp_irq_req(cmp_irq_req), .ovf_irq_req(ovf_irq_req),
        .compare_out_pin(compare_out_pin), .compare_out_override(compare_out_override));
    pin_model pm (.pclk(pclk), .n_edges(n_edges), .go(go), .ext_count_pin(ext_count_pin));

    // Free-running 25 MHz clock.
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic check(input string s, input logic [32:0] seen, input logic [32:0] e);
        n_tests++;
        if (seen !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", s, e, seen);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // One APB transfer; the request is held until pready is seen at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    // A read leaves its expectation, error bit on top, for the monitor below.
    task automatic rd(input string s, input logic [7:0] a, input logic [32:0] e);
        nm_q.push_back(s);
        exp_q.push_back(e);
        apb(1'b0, a, 8'h00);
    endtask

    // Cycles until the compare output next changes, bounded against a dead pin.
    task automatic gap(output int c);
        logic v;
        v = compare_out_pin;
        c = 0;
        while (compare_out_pin === v && c < 3000)
        begin
            @(posedge pclk);
            c++;
        end
    endtask

    // Two settling transitions first, since the first period after a mode change is partial.
    task automatic pwm(input string s, input logic [7:0] ctl, input int ehi, input int eper);
        wr(OFS_CONTROL, 8'h00);
        wr(OFS_COMPARE, r[7:0]);
        wr(OFS_CONTROL, ctl);
        gap(n);
        gap(n);
        if (compare_out_pin !== 1'b1)
            gap(n);
        gap(hi);
        gap(lo);
        check({s, " high"}, hi, ehi);
        check({s, " period"}, hi + lo, eper);
        $display("test %s done", s);
    endtask

    // Every completed read is compared with the oldest note in the queue.
    always @(posedge pclk)
        if (psel && penable && pready && !pwrite && exp_q.size() > 0)
            check(nm_q.pop_front(), {pslverr, prdata}, exp_q.pop_front());

    // Watchdog sized well above the longest scenario mix.
    initial
    begin
        repeat (60000) @(posedge pclk);
        bad_count++;
        wrap_up();
    end

    // Main sequence: reset, then one scenario group per behaviour.
    initial
    begin
        seed = 45300;
        {presetn, psel, penable, pwrite, global_irq_en, cmp_vector_ack, ovf_vector_ack} = '0;
        {go, n_edges, paddr, pwdata} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (offs[i])
            rd("reset value", offs[i], 33'h0);
        rd("unmapped", 8'h14, 33'h1_0000_0000);
        $display("test reset done");
        wr(OFS_CONTROL, 8'h90);
        rd("force reads zero", OFS_CONTROL, 33'h10);
        check("force toggle", compare_out_pin, 1'b1);
        check("override", compare_out_override, 1'b1);
        wr(OFS_CONTROL, 8'hA0);
        check("force clear", compare_out_pin, 1'b0);
        wr(OFS_CONTROL, 8'hB0);
        check("force set", compare_out_pin, 1'b1);
        wr(OFS_COUNT, 8'h07);
        wr(OFS_CONTROL, 8'hE0);
        check("ctc force", compare_out_pin, 1'b0);
        rd("force keeps count", OFS_COUNT, 33'h07);
        rd("force no flag", OFS_FLAGS, 33'h0);
        wr(OFS_CONTROL, 8'h38);
        check("pwm entry keeps output", compare_out_pin, 1'b0);
        $display("test force done");
        // Leave PWM first so the compare value loads at once and the block is real.
        wr(OFS_CONTROL, 8'h10);
        wr(OFS_COMPARE, 8'h05);
        wr(OFS_COUNT, 8'h05);
        wr(OFS_CONTROL, 8'h11);
        wr(OFS_CONTROL, 8'h10);
        rd("match blocked", OFS_FLAGS, 33'h0);
        check("no toggle", compare_out_pin, 1'b0);
        $display("test count write done");
        wr(OFS_COMPARE, 8'h80);
        // Only the two defined mask bits are ever written.
        wr(OFS_MASK, 8'h03);
        rd("mask", OFS_MASK, 33'h03);
        wr(OFS_COUNT, 8'hFD);
        wr(OFS_CONTROL, 8'h01);
        wr(OFS_CONTROL, 8'h00);
        rd("overflow flag", OFS_FLAGS, 33'h01);
        global_irq_en <= 1'b1;
        @(posedge pclk);
        check("ovf irq", ovf_irq_req, 1'b1);
        check("cmp irq idle", cmp_irq_req, 1'b0);
        check("no override", compare_out_override, 1'b0);
        global_irq_en <= 1'b0;
        @(posedge pclk);
        check("ovf irq masked", ovf_irq_req, 1'b0);
        wr(OFS_FLAGS, 8'h01);
        rd("ovf cleared", OFS_FLAGS, 33'h0);
        $display("test overflow done");
        foreach (divs[i])
        begin
            r = (i == 0) ? 3 + ($unsigned($random(seed)) % 40) : 1;
            wr(OFS_CONTROL, 8'h00);
            wr(OFS_COUNT, 8'h00);
            wr(OFS_COMPARE, r[7:0]);
            wr(OFS_CONTROL, 8'h50 + 8'(i + 1));
            gap(n);
            gap(n);
            check("ctc toggle period", n, (r + 1) * divs[i]);
        end
        global_irq_en <= 1'b1;
        @(posedge pclk);
        check("cmp irq", cmp_irq_req, 1'b1);
        wr(OFS_CONTROL, 8'h50);
        cmp_vector_ack <= 1'b1;
        @(posedge pclk);
        cmp_vector_ack <= 1'b0;
        @(posedge pclk);
        rd("vector clears", OFS_FLAGS, 33'h0);
        $display("test clear on match done");
        r = 16 + ($unsigned($random(seed)) % 100);
        pwm("fast pwm", 8'h69, r + 1, 256);
        pwm("phase pwm", 8'h39, 510 - 2 * r, 510);
        for (int s = 6; s < 8; s++)
        begin
            wr(OFS_CONTROL, 8'h00);
            wr(OFS_COUNT, 8'h00);
            wr(OFS_CONTROL, s[7:0]);
            n_edges <= 4'(3 + ($unsigned($random(seed)) % 8));
            go <= 1'b1;
            repeat (70) @(posedge pclk);
            go <= 1'b0;
            wr(OFS_CONTROL, 8'h00);
            rd("external edges", OFS_COUNT, {29'h0, n_edges});
        end
        $display("test external clock done");
        wrap_up();
    end
endmodule
